// file: src/udc_pkg.sv
// package for the up/down event counter: register map, field layout, modes
// assumes a 32-bit apb master and a 10 mhz machine clock
package udc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_CTRL0 = 8'h08;
  localparam logic [7:0] OFS_CTRL1 = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_PINSEL = 8'h18;
  // control field positions (per channel control word)
  localparam int CF_MODE = 0;  // 2 bits
  localparam int CF_CLKS = 2;  // timer clock select
  localparam int CF_EDGE = 3;  // 2 bits
  localparam int CF_IDXG = 5;  // index pin: 0 clear, 1 gate
  localparam int CF_CMPE = 6;
  localparam int CF_RLDE = 7;
  localparam int CF_CMPC = 8;  // clear on compare
  localparam int CF_JOIN = 9;  // 16-bit join (channel 0 word only)
  localparam int CF_CLR = 10;  // write one: clear counter
  // status bits per channel, channel 1 at +4
  localparam int SF_CMP = 0;
  localparam int SF_UDF = 1;
  localparam int SF_OVF = 2;
  localparam int SF_DIRCH = 3;
  localparam int SF_DIR0 = 8;  // direction flags, read-only
  // reset values
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [5:0] PINSEL_RST = 6'h00;
  // internal count clock select: A ticks every 2 machine cycles, B every 8
  localparam logic [7:0] PRESC_A = 8'h01;
  localparam logic [7:0] PRESC_B = 8'h07;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0, MODE_UPDN = 2'h1, MODE_PH2 = 2'h2, MODE_PH8 = 2'h3
  } udc_mode_t;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0, EDGE_FALL = 2'h1, EDGE_RISE = 2'h2, EDGE_BOTH = 2'h3
  } udc_edge_t;
  typedef struct packed {
    logic [10:0] ctrl1;
    logic [10:0] ctrl0;
    logic [7:0] rld1;
    logic [7:0] rld0;
    logic [7:0] cnt1;
    logic [7:0] cnt0;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [5:0] pinsel;
    logic [1:0] dir;
    logic [1:0] stepped;
    logic [7:0] presc;
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] pinv;
    logic [31:0] prdata;
  } udc_state_t;
endpackage

// file: src/udc_top.sv
// up/down event counter: two 8-bit counters, joinable, with apb registers
// assumes a 10 mhz clock, async active-low reset, pins asynchronous
// Behaviour
// - two 8-bit counters, reload registers, six pins
// - each 8-bit counter wraps over its byte range
// - joined counter spans 0 to 65535
// - timer, up/down, phase x2, phase x8 modes
// - timer counts one of two internal clocks
// - edge select: fall, rise, both, off
// - a/b phase relation sets count direction
// - index pin clears counter or gates counting
// - compare and reload enabled independently
// - compare match interrupts, optionally clears counter
// - underflow reloads counter and interrupts
// - both enabled: bounded range both ways
// - separate compare, underflow, overflow interrupt enables
// - flag keeps last count direction
// - direction change raises interrupt
// - pin select gates pin, resets to zero
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module udc_top
  import udc_pkg::*;
(
  input wire logic CLOCK_I, // machine clock
  input wire logic ARST_N_I, // async reset, active low
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb direction
  input wire logic [7:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error on unmapped address
  input wire logic [5:0] EVENT_PIN_I, // a0,b0,z0,a1,b1,z1
  output logic [5:0] PORT_IN_O, // synchronised pins for plain port use
  output logic IRQ_O // level interrupt
);
  udc_state_t r, n;
  logic wr, rd, mapped;
  // step decision per channel: inc / dec
  logic [1:0] inc, dec;
  // pin level as it is about to be accepted: edges are seen on the accepting edge
  logic [5:0] lvl;

  // address decode, used by the error answer only; the read mux decodes through its own case
  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {OFS_COUNT, OFS_RELOAD, OFS_CTRL0, OFS_CTRL1, OFS_STAT,
                     OFS_MASK, OFS_PINSEL};
  endfunction

  // zero-wait slave: every access completes in its access cycle
  assign mapped = is_mapped(PADDR_I);
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O = r.prdata;
  assign PORT_IN_O = r.pinv;
  assign IRQ_O = |(r.stat & r.mask);
  // where stages two and three agree the new level is taken, else the old one stays
  assign lvl = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.pinv);

  // per-channel step decode from the qualified pins
  generate
    for (genvar c = 0; c < 2; c++) begin : g_step
      logic [10:0] ctl;
      logic a, b, z, ap, bp, a_r, a_f, b_r, b_f, gate, tick;
      assign ctl = c ? r.ctrl1 : r.ctrl0;
      // pins not selected read as zero to the counter
      assign a = lvl[3*c] & r.pinsel[3*c];
      assign b = lvl[3*c+1] & r.pinsel[3*c+1];
      assign z = lvl[3*c+2] & r.pinsel[3*c+2];
      assign ap = r.pinv[3*c] & r.pinsel[3*c];
      assign bp = r.pinv[3*c+1] & r.pinsel[3*c+1];
      assign a_r = a & ~ap;
      assign a_f = ~a & ap;
      assign b_r = b & ~bp;
      assign b_f = ~b & bp;
      // gate mode: count only while index is high
      assign gate = !ctl[CF_IDXG] || z;
      assign tick = ctl[CF_CLKS] ? (r.presc == PRESC_B) : (r.presc[0] == PRESC_A[0]);
      always_comb begin
        inc[c] = 1'b0;
        dec[c] = 1'b0;
        case (udc_mode_t'(ctl[CF_MODE +: 2]))
          MODE_TIMER: inc[c] = tick;
          MODE_UPDN: begin
            // a edges count up, b edges count down
            case (udc_edge_t'(ctl[CF_EDGE +: 2]))
              EDGE_FALL: begin inc[c] = a_f; dec[c] = b_f; end
              EDGE_RISE: begin inc[c] = a_r; dec[c] = b_r; end
              EDGE_BOTH: begin inc[c] = a_r | a_f; dec[c] = b_r | b_f; end
              default: ;
            endcase
          end
          MODE_PH2: begin
            // both edges of a, direction from b level
            inc[c] = (a_r & ~b) | (a_f & b);
            dec[c] = (a_r & b) | (a_f & ~b);
          end
          MODE_PH8: begin
            // every edge of a and b
            inc[c] = (a_r & ~b) | (a_f & b) | (b_r & a) | (b_f & ~a);
            dec[c] = (a_r & b) | (a_f & ~b) | (b_r & ~a) | (b_f & a);
          end
          default: ;
        endcase
        if (!gate) begin
          inc[c] = 1'b0;
          dec[c] = 1'b0;
        end
        if (inc[c] && dec[c]) begin
          inc[c] = 1'b0;
          dec[c] = 1'b0;
        end
      end
    end
  endgenerate

  // next state: sync, counters, events, registers
  always_comb begin
    logic join16;
    logic [15:0] c16, r16;
    logic [3:0] ev0, ev1;
    logic clr0, clr1, i0, d0, i1, d1;
    n = r;
    c16 = 16'h0000;
    r16 = 16'h0000;
    join16 = r.ctrl0[CF_JOIN];
    ev0 = 4'h0;
    ev1 = 4'h0;
    // three-stage sync; a level counts once stages two and three agree
    n.s1 = EVENT_PIN_I;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int k = 0; k < 6; k++) begin
      if (r.s2[k] == r.s3[k]) n.pinv[k] = r.s3[k];
    end
    n.presc = (r.presc == PRESC_B) ? 8'h00 : r.presc + 8'h01;
    n.stepped = r.stepped;
    clr0 = wr && PADDR_I == OFS_CTRL0 && PWDATA_I[CF_CLR];
    clr1 = wr && PADDR_I == OFS_CTRL1 && PWDATA_I[CF_CLR];
    // joined mode is driven by channel 0 controls only, save the channel 1 clear bit, which still zeroes the upper byte
    i0 = inc[0];
    d0 = dec[0];
    i1 = join16 ? 1'b0 : inc[1];
    d1 = join16 ? 1'b0 : dec[1];
    if (join16) begin
      c16 = {r.cnt1, r.cnt0};
      r16 = {r.rld1, r.rld0};
      if (i0 || d0) begin
        if (r.ctrl0[CF_CMPE] && c16 == r16) ev0[SF_CMP] = 1'b1;
        if (i0) begin
          if (c16 == 16'hffff) ev0[SF_OVF] = 1'b1;
          c16 = c16 + 16'h0001;
        end else if (c16 == 16'h0000) begin
          ev0[SF_UDF] = 1'b1;
          c16 = r.ctrl0[CF_RLDE] ? r16 : 16'hffff;
        end else begin
          c16 = c16 - 16'h0001;
        end
        if (ev0[SF_CMP] && (r.ctrl0[CF_CMPC] || r.ctrl0[CF_RLDE])) c16 = 16'h0000;
        if (ev0[SF_UDF] && !r.ctrl0[CF_RLDE]) ev0[SF_UDF] = 1'b0;
      end
      n.cnt0 = c16[7:0];
      n.cnt1 = c16[15:8];
    end else begin
      // independent 8-bit channels, each wrapping over 0..255
      if (i0 || d0) begin
        if (r.ctrl0[CF_CMPE] && r.cnt0 == r.rld0) ev0[SF_CMP] = 1'b1;
        if (i0) begin
          if (r.cnt0 == 8'hff) ev0[SF_OVF] = 1'b1;
          n.cnt0 = r.cnt0 + 8'h01;
        end else if (r.cnt0 == 8'h00) begin
          ev0[SF_UDF] = r.ctrl0[CF_RLDE];
          n.cnt0 = r.ctrl0[CF_RLDE] ? r.rld0 : 8'hff;
        end else n.cnt0 = r.cnt0 - 8'h01;
        if (ev0[SF_CMP] && (r.ctrl0[CF_CMPC] || r.ctrl0[CF_RLDE])) n.cnt0 = 8'h00;
      end
      if (i1 || d1) begin
        if (r.ctrl1[CF_CMPE] && r.cnt1 == r.rld1) ev1[SF_CMP] = 1'b1;
        if (i1) begin
          if (r.cnt1 == 8'hff) ev1[SF_OVF] = 1'b1;
          n.cnt1 = r.cnt1 + 8'h01;
        end else if (r.cnt1 == 8'h00) begin
          ev1[SF_UDF] = r.ctrl1[CF_RLDE];
          n.cnt1 = r.ctrl1[CF_RLDE] ? r.rld1 : 8'hff;
        end else n.cnt1 = r.cnt1 - 8'h01;
        if (ev1[SF_CMP] && (r.ctrl1[CF_CMPC] || r.ctrl1[CF_RLDE])) n.cnt1 = 8'h00;
      end
    end
    // index clear function: high index resets the counter
    if (!r.ctrl0[CF_IDXG] && r.pinv[2] && r.pinsel[2]) begin
      n.cnt0 = 8'h00;
      if (join16) n.cnt1 = 8'h00;
    end
    if (!join16 && !r.ctrl1[CF_IDXG] && r.pinv[5] && r.pinsel[5]) n.cnt1 = 8'h00;
    // the upper byte is cleared too when join is set now or in the control word being written
    if (clr0) begin
      n.cnt0 = 8'h00;
      if (join16 || PWDATA_I[CF_JOIN]) n.cnt1 = 8'h00;
    end
    if (clr1) n.cnt1 = 8'h00;
    // direction flag and change event
    if (i0 || d0) begin
      n.dir[0] = i0;
      n.stepped[0] = 1'b1;
      if (r.stepped[0] && r.dir[0] != i0) ev0[SF_DIRCH] = 1'b1;
    end
    if (i1 || d1) begin
      n.dir[1] = i1;
      n.stepped[1] = 1'b1;
      if (r.stepped[1] && r.dir[1] != i1) ev1[SF_DIRCH] = 1'b1;
    end
    // register writes
    if (wr) begin
      case (PADDR_I)
        OFS_RELOAD: begin
          n.rld0 = PWDATA_I[7:0];
          n.rld1 = PWDATA_I[15:8];
        end
        OFS_CTRL0: n.ctrl0 = {1'b0, PWDATA_I[9:0]};
        OFS_CTRL1: n.ctrl1 = {2'b00, PWDATA_I[8:0]};
        OFS_MASK: n.mask = PWDATA_I[7:0];
        OFS_PINSEL: n.pinsel = PWDATA_I[5:0];
        default: ;
      endcase
    end
    // read data is caught in the setup phase so it stands through the access
    // phase; the status read clears only the bits it reported, so an event
    // landing between setup and access is not lost, and new events win
    n.prdata = r.prdata;
    if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      case (PADDR_I)
        OFS_COUNT: n.prdata = {16'h0000, r.cnt1, r.cnt0};
        OFS_RELOAD: n.prdata = {16'h0000, r.rld1, r.rld0};
        OFS_CTRL0: n.prdata = {22'h000000, r.ctrl0[9:0]};
        OFS_CTRL1: n.prdata = {23'h000000, r.ctrl1[8:0]};
        OFS_STAT: n.prdata = {22'h000000, r.dir, r.stat};
        OFS_MASK: n.prdata = {24'h000000, r.mask};
        OFS_PINSEL: n.prdata = {26'h0000000, r.pinsel};
        default: n.prdata = 32'h00000000;
      endcase
    end
    if (rd && PADDR_I == OFS_STAT) n.stat = r.stat & ~r.prdata[7:0];
    n.stat = n.stat | {ev1, ev0};
  end

  // single state register
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      r <= '0;
      r.ctrl0 <= CTRL_RST;
      r.ctrl1 <= CTRL_RST;
      r.mask <= MASK_RST;
      r.pinsel <= PINSEL_RST;
    end else begin
      r <= n;
    end
  end
endmodule // udc_top

// file: verif/udc_asserts.sv
// checker: apb, pin path and interrupt relations of the counter
// assumes binding into udc_top, ports only
`timescale 1ns/1ps
module udc_asserts
  import udc_pkg::*;
(
  input wire logic CLOCK_I, // clk
  input wire logic ARST_N_I, // rst
  input wire logic PSEL_I, // apb
  input wire logic PENABLE_I, // apb
  input wire logic PWRITE_I, // apb
  input wire logic [7:0] PADDR_I, // apb
  input wire logic [31:0] PWDATA_I, // apb
  input wire logic [31:0] PRDATA_O, // apb
  input wire logic PREADY_O, // apb
  input wire logic PSLVERR_O, // apb
  input wire logic [5:0] EVENT_PIN_I, // pins
  input wire logic [5:0] PORT_IN_O, // synced
  input wire logic IRQ_O // irq
);
  logic [1:0] up_r; // edges since reset
  logic mask_nz_r; // last mask write nonzero
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  // pin check waits out the synchroniser after each reset
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      up_r <= 2'h0;
      mask_nz_r <= 1'b0;
    end else begin
      if (up_r != 2'h3) up_r <= up_r + 2'h1;
      if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_MASK)
        mask_nz_r <= |PWDATA_I[7:0];
    end
  end
  chk_ready_high: assert property (PREADY_O) else $error("ready low");
  chk_pin_sync: assert property (up_r == 2'h3 && $past(EVENT_PIN_I, 4) == $past(EVENT_PIN_I, 3)
    |-> PORT_IN_O == $past(EVENT_PIN_I, 4))
    else $error("pin path");
  chk_err_map: assert property (PSEL_I && PENABLE_I
    |-> PSLVERR_O == (PADDR_I > OFS_PINSEL || PADDR_I[1:0] != 2'h0)) else $error("decode");
  chk_err_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O) else $error("idle err");
  chk_rd_hold: assert property (!$past(PSEL_I && !PENABLE_I && !PWRITE_I) |-> $stable(PRDATA_O))
    else $error("rdata moved");
  chk_bad_rd_zero: assert property (PSEL_I && PENABLE_I && !PWRITE_I && PSLVERR_O
    |-> PRDATA_O == 32'h0) else $error("unmapped data");
  chk_irq_masked: assert property (!mask_nz_r |-> !IRQ_O) else $error("masked irq");
  chk_mask_off: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFS_MASK
    && PWDATA_I[7:0] == 8'h00 |=> !IRQ_O [*2]) else $error("irq after mask off");
endmodule // udc_asserts

bind udc_top udc_asserts chk_i (.*);

// file: verif/udc_pin_src.sv
// event pin source standing in for an encoder and plain event lines
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module udc_pin_src (
  input wire logic clk_i, // machine clock
  output logic [5:0] pins_o // a0,b0,z0,a1,b1,z1
);
  initial pins_o = 6'h00;
  // one level change, held g+1 cycles so the synchroniser never misses it
  task automatic tg(input int i, input int g);
    @(posedge clk_i);
    pins_o[i] <= ~pins_o[i];
    repeat (g) @(posedge clk_i);
  endtask
  // quadrature on channel c, a leads b when f is set; then settle
  task automatic quad(input int c, input bit f, input int n, input int g);
    repeat (2 * n) begin
      tg(3 * c + (f ? 0 : 1), g);
      tg(3 * c + (f ? 1 : 0), g);
    end
    repeat (6) @(posedge clk_i);
  endtask
  // full pulses on one pin, then settle past the pin path
  task automatic pulse(input int i, input int n, input int g);
    repeat (2 * n) tg(i, g);
    repeat (6) @(posedge clk_i);
  endtask
endmodule // udc_pin_src

// file: verif/tb.sv
// testbench for udc_top: apb master, pin source, self-checking
// assumes udc_pkg offsets and control layout
`timescale 1ns/1ps
module tb;
  import udc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, irq;
  logic [5:0] pins, port_in;
  int seed = 26, mismatches = 0, num_checks = 0, n;
  always #50 clk = ~clk;
  udc_top dut (.CLOCK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .EVENT_PIN_I(pins), .PORT_IN_O(port_in),
    .IRQ_O(irq));
  udc_pin_src src (.clk_i(clk), .pins_o(pins));
  // every reconfiguration also clears the counter
  function automatic logic [31:0] cfg(logic [1:0] m, logic [1:0] e, logic [31:0] f);
    return {30'h0, m} | {30'h0, e} << CF_EDGE | f | 32'h1 << CF_CLR;
  endfunction
  // apb transfer; read data is taken at the edge that sees ready, then one idle cycle
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(a, 1'b0, 32'h0);
    chk(rv & m, e);
  endtask
  task automatic results;
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(8'h1c, 1'b1, 32'hffffffff);
    for (int a = 0; a <= 8'h1c; a += 4)
      if (a != 4) rd(a[7:0], 32'h0, a == 0 ? 32'hffff0000 : a == 16 ? 32'hfffffc00 : 32'hffffffff);
    xfer(OFS_PINSEL, 1'b1, 32'h3f);
    // every edge selection, random pulse counts
    for (int e = 0; e < 4; e++) begin
      n = 1 + $unsigned($random(seed)) % 20;
      xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, e[1:0], 0));
      src.pulse(0, n, 1);
      rd(OFS_COUNT, n * ((e + 1) / 2), 32'hff);
    end
    xfer(OFS_PINSEL, 1'b1, 32'h0);
    src.pulse(0, 3, 1);
    rd(OFS_COUNT, 2 * n, 32'hff);
    xfer(OFS_PINSEL, 1'b1, 32'h3f);
    // forward then slower reverse must come back to zero
    for (int m = 2; m < 4; m++) begin
      n = 1 + $unsigned($random(seed)) % 10;
      xfer(OFS_CTRL0, 1'b1, cfg(m[1:0], EDGE_OFF, 0));
      src.quad(0, 1'b1, n, 1);
      xfer(OFS_STAT, 1'b0, 32'h0);
      src.quad(0, 1'b0, n, 3);
      rd(OFS_COUNT, 32'h0, 32'hff);
      rd(OFS_STAT, 32'h8, 32'h8);
    end
    xfer(OFS_RELOAD, 1'b1, 32'h5);
    xfer(OFS_MASK, 1'b1, 32'h1);
    xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, EDGE_RISE, 32'h1 << CF_CMPE));
    xfer(OFS_STAT, 1'b0, 32'h0);
    src.pulse(0, 7, 1);
    chk(irq, 1'b1);
    xfer(OFS_MASK, 1'b1, 32'h0);
    chk(irq, 1'b0);
    xfer(OFS_MASK, 1'b1, 32'h1);
    rd(OFS_COUNT, 32'h7, 32'hff);
    rd(OFS_STAT, 32'h1, 32'h1);
    chk(irq, 1'b0);
    xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, EDGE_RISE, 32'h1 << CF_CMPE | 32'h1 << CF_CMPC));
    src.pulse(0, 6, 1);
    rd(OFS_COUNT, 32'h0, 32'hff);
    xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, EDGE_RISE, 32'h3 << CF_CMPE));
    src.pulse(1, 1, 1);
    rd(OFS_COUNT, 32'h5, 32'hff);
    src.pulse(0, 1, 1);
    rd(OFS_COUNT, 32'h0, 32'hff);
    rd(OFS_STAT, 32'h3, 32'h3);
    xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, EDGE_RISE, 0));
    src.pulse(0, 3, 1);
    src.pulse(2, 1, 2);
    rd(OFS_COUNT, 32'h0, 32'hff);
    n = 256 + $unsigned($random(seed)) % 200;
    xfer(OFS_CTRL0, 1'b1, cfg(MODE_UPDN, EDGE_RISE, 32'h1 << CF_JOIN));
    src.pulse(0, n, 1);
    rd(OFS_COUNT, n, 32'hffff);
    src.pulse(1, n + 1, 1);
    rd(OFS_COUNT, 32'hffff, 32'hffff);
    results();
  end
  // cut a hang short well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // tb
